// ### rtl/hepb_pkg.sv
`default_nettype none
package hepb_pkg;

  // event codes and length bytes (length counts the bytes after it)
  localparam logic [7:0] EV_CONN_TIMING = 8'h89;
  localparam logic [7:0] EV_KEY_SHOW = 8'h8e;
  localparam logic [7:0] EV_KEY_ENTRY = 8'h8f;
  localparam logic [7:0] EV_CREDIT = 8'h8a;
  localparam logic [7:0] LEN_CONN_TIMING = 8'h07;
  localparam logic [7:0] LEN_KEY_SHOW = 8'h07;
  localparam logic [7:0] LEN_KEY_ENTRY = 8'h02;
  localparam logic [7:0] LEN_CREDIT = 8'h02;
  localparam logic [7:0] KEY_KIND_PASSKEY = 8'h01;
  localparam logic [15:0] LATENCY_MAX = 16'h03e8;
  localparam logic [7:0] ASCII_ZERO = 8'h30;
  localparam logic [7:0] ASCII_NINE = 8'h39;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CONN = 8'h04;
  localparam logic [7:0] OFS_TIMEOUT = 8'h08;
  localparam logic [7:0] OFS_PASSKEY = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;

  // field positions
  localparam int CTRL_CFG_DONE = 0;
  localparam int CTRL_MITM = 1;
  localparam int CTRL_IO_CAP = 2;
  localparam int STAT_BUSY = 0;
  localparam int STAT_KEY_WAIT = 1;
  localparam int STAT_BOND_FAIL = 2;

  // reset values
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [31:0] CONN_RST = 32'h0000_0000;
  localparam logic [15:0] TIMEOUT_RST = 16'h0000;
  localparam logic [23:0] PASSKEY_RST = 24'h00_0000;

  // passkey supply deadline
  localparam longint KEY_WAIT_S = 30;
  localparam longint CLK_HZ = 50_000_000;
  localparam logic [31:0] KEY_WAIT_CYC = 32'(KEY_WAIT_S * CLK_HZ);

  typedef enum logic [1:0] {
    HEPB_IDLE = 2'b01,
    HEPB_SEND = 2'b10
  } hepb_state_e;

  typedef enum logic [3:0] {
    HEPB_K_TIMING = 4'b0001,
    HEPB_K_SHOW = 4'b0010,
    HEPB_K_ENTRY = 4'b0100,
    HEPB_K_CREDIT = 4'b1000
  } hepb_kind_e;

  typedef struct packed {
    logic [7:0] data;
    logic last;
  } hepb_byte_s;

endpackage
`default_nettype wire

// ### rtl/hepb_builder.sv
// The placing of the registers and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

// How it works
// [RULE1] timing report: code 0x89, length 7
// [RULE2] report on connect and on parameter update
// [RULE3] interval sent msb first, 1.25 ms units
// [RULE4] latency sent lsb first, capped 0x03e8
// [RULE5] link-loss timeout in 10 ms units
// [RULE6] show request: code 0x8e, length 7
// [RULE7] six ascii digits, leading zeros, no null
// [RULE8] show only when configured, mitm, io ok
// [RULE9] entry request: code 0x8f, length 2, kind 0x01
// [RULE10] entry only when configured, mitm, io ok
// [RULE11] controller supplies passkey within 30 s
// [RULE12] no passkey in 30 s: fail, drop link
// [RULE13] credit return: code 0x8a, length 2
// [RULE14] credits freed since last return
// [RULE15] length, code, then content in order
// [RULE16] controller tracks credits, stalls at zero; the controller model counts credits but never stalls on them
module hepb_builder #(
  parameter int ADDR_W = 8,
  parameter logic [31:0] KEY_WAIT_CYCLES = hepb_pkg::KEY_WAIT_CYC
) (
  // clock, reset, enable
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic clk_en,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // link and pairing events, one-cycle pulses
  input wire logic conn_established,
  input wire logic conn_params_updated,
  input wire logic pair_show_req,
  input wire logic pair_entry_req,
  input wire logic passkey_supply_command,
  input wire logic data_cmd_freed,
  // pairing outcome, one-cycle pulses
  output logic bond_fail,
  output logic link_terminate,
  // event byte stream
  output hepb_pkg::hepb_byte_s tx_byte,
  output logic tx_valid,
  input wire logic tx_ready
);
  import hepb_pkg::*;

  function automatic logic [7:0] digit_ascii(input logic [3:0] nib);
    digit_ascii = (nib > 4'h9) ? ASCII_NINE : (ASCII_ZERO | {4'h0, nib});
  endfunction

  logic [2:0] ctrl;
  logic [31:0] conn;
  logic [15:0] link_timeout;
  logic [23:0] passkey;
  logic bond_failed;
  hepb_state_e state;
  hepb_kind_e kind;
  logic [63:0] frm;
  logic [3:0] left;
  logic timing_pend, show_pend, entry_pend;
  logic [7:0] credit;
  logic key_wait;
  logic [31:0] wait_cnt;
  logic skid_v;
  hepb_byte_s skid;
  logic pair_ok, push, take, fr_last, key_expire;
  logic take_timing, take_show, take_entry, take_credit;
  logic wr_acc;
  logic [15:0] lat_capped;

  assign pair_ok = ctrl[CTRL_CFG_DONE] & ctrl[CTRL_MITM] & ctrl[CTRL_IO_CAP];
  assign push = (state == HEPB_SEND) & ~skid_v;
  assign fr_last = (left == 4'h1);
  assign take = (state == HEPB_IDLE);
  assign take_timing = take & timing_pend;
  assign take_show = take & ~timing_pend & show_pend;
  assign take_entry = take & ~timing_pend & ~show_pend & entry_pend;
  assign take_credit = take & ~timing_pend & ~show_pend & ~entry_pend
                       & (credit != 8'h00);
  assign key_expire = key_wait & (wait_cnt == KEY_WAIT_CYCLES - 32'h1)
                      & ~passkey_supply_command;
  assign wr_acc = psel & penable & pready & pwrite;
  assign lat_capped = (conn[31:16] > LATENCY_MAX) ? LATENCY_MAX : conn[31:16];

  // apb: zero wait states, answer registered in the setup cycle
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (clk_en) begin
      pready <= psel & ~penable;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      if (psel & ~penable) begin
        if (paddr == ADDR_W'(OFS_CTRL)) begin
          prdata <= {29'h0, ctrl};
        end else if (paddr == ADDR_W'(OFS_CONN)) begin
          prdata <= conn;
        end else if (paddr == ADDR_W'(OFS_TIMEOUT)) begin
          prdata <= {16'h0, link_timeout};
        end else if (paddr == ADDR_W'(OFS_PASSKEY)) begin
          prdata <= {8'h0, passkey};
        end else if (paddr == ADDR_W'(OFS_STATUS)) begin
          prdata <= {16'h0, credit, 5'h0, bond_failed, key_wait,
                     state == HEPB_SEND};
        end else begin
          pslverr <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      ctrl <= CTRL_RST;
      conn <= CONN_RST;
      link_timeout <= TIMEOUT_RST;
      passkey <= PASSKEY_RST;
    end else if (clk_en && wr_acc) begin
      if (paddr == ADDR_W'(OFS_CTRL)) begin
        ctrl <= pwdata[2:0];
      end else if (paddr == ADDR_W'(OFS_CONN)) begin
        conn <= pwdata;
      end else if (paddr == ADDR_W'(OFS_TIMEOUT)) begin
        link_timeout <= pwdata[15:0];
      end else if (paddr == ADDR_W'(OFS_PASSKEY)) begin
        passkey <= pwdata[23:0];
      end
    end
  end

  // sticky failure flag; a new failure beats a clear
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      bond_failed <= 1'b0;
    end else if (clk_en) begin
      bond_failed <= key_expire | (bond_failed & ~(wr_acc
        & (paddr == ADDR_W'(OFS_STATUS)) & pwdata[STAT_BOND_FAIL]));
    end
  end

  // pending events; a new event in the take cycle stays pending
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      timing_pend <= 1'b0;
      show_pend <= 1'b0;
      entry_pend <= 1'b0;
    end else if (clk_en) begin
      // [RULE2] connect or update
      timing_pend <= conn_established | conn_params_updated
                     | (timing_pend & ~take_timing);
      // [RULE8] gated show request
      show_pend <= (pair_show_req & pair_ok) | (show_pend & ~take_show);
      // [RULE10] gated entry request
      entry_pend <= (pair_entry_req & pair_ok) | (entry_pend & ~take_entry);
    end
  end

  // credits freed since the snapshot taken at the last return
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      credit <= 8'h00;
    end else if (clk_en) begin
      // [RULE14] snapshot and restart
      if (take_credit) begin
        credit <= {7'h0, data_cmd_freed};
      end else if (data_cmd_freed && credit != 8'hff) begin
        credit <= credit + 8'h01;
      end
    end
  end

  // framer: load a whole packet, then shift bytes out lowest first
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      state <= HEPB_IDLE;
      kind <= HEPB_K_TIMING;
      frm <= 64'h0;
      left <= 4'h0;
    end else if (clk_en) begin
      case (state)
        HEPB_IDLE: begin
          // [RULE15] length, code, content
          if (take_timing) begin
            // [RULE1] [RULE3] [RULE4] [RULE5] timing layout
            frm <= {link_timeout[15:8], link_timeout[7:0],
                    lat_capped[15:8], lat_capped[7:0],
                    conn[7:0], conn[15:8], EV_CONN_TIMING, LEN_CONN_TIMING};
            kind <= HEPB_K_TIMING;
            left <= 4'h8;
            state <= HEPB_SEND;
          end else if (take_show) begin
            // [RULE6] [RULE7] ascii digits, first digit leads
            frm <= {digit_ascii(passkey[3:0]), digit_ascii(passkey[7:4]),
                    digit_ascii(passkey[11:8]), digit_ascii(passkey[15:12]),
                    digit_ascii(passkey[19:16]),
                    digit_ascii(passkey[23:20]), EV_KEY_SHOW, LEN_KEY_SHOW};
            kind <= HEPB_K_SHOW;
            left <= 4'h8;
            state <= HEPB_SEND;
          end else if (take_entry) begin
            // [RULE9] entry layout
            frm <= {40'h0, KEY_KIND_PASSKEY, EV_KEY_ENTRY, LEN_KEY_ENTRY};
            kind <= HEPB_K_ENTRY;
            left <= 4'h3;
            state <= HEPB_SEND;
          end else if (take_credit) begin
            // [RULE13] credit layout
            frm <= {40'h0, credit, EV_CREDIT, LEN_CREDIT};
            kind <= HEPB_K_CREDIT;
            left <= 4'h3;
            state <= HEPB_SEND;
          end
        end
        HEPB_SEND: begin
          if (push) begin
            frm <= {8'h00, frm[63:8]};
            left <= left - 4'h1;
            if (fr_last) begin
              state <= HEPB_IDLE;
            end
          end
        end
        default: state <= HEPB_IDLE;
      endcase
    end
  end

  // two-entry buffer: output stage plus skid, so a stall loses nothing
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      tx_valid <= 1'b0;
      tx_byte <= '0;
      skid_v <= 1'b0;
      skid <= '0;
    end else if (clk_en) begin
      if (!tx_valid || tx_ready) begin
        if (skid_v) begin
          tx_byte <= skid;
          skid_v <= 1'b0;
        end else if (push) begin
          tx_byte <= '{data: frm[7:0], last: fr_last};
        end
        tx_valid <= skid_v | push;
      end else if (push) begin
        skid <= '{data: frm[7:0], last: fr_last};
        skid_v <= 1'b1;
      end
    end
  end

  // deadline starts when the entry request leaves the framer
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      key_wait <= 1'b0;
      wait_cnt <= 32'h0;
      bond_fail <= 1'b0;
      link_terminate <= 1'b0;
    end else if (clk_en) begin
      // [RULE12] fail and drop on expiry
      bond_fail <= key_expire;
      link_terminate <= key_expire;
      if (push && fr_last && kind == HEPB_K_ENTRY) begin
        key_wait <= 1'b1;
        wait_cnt <= 32'h0;
      end else if (passkey_supply_command || key_expire) begin
        // [RULE11] supply ends the wait
        key_wait <= 1'b0;
        wait_cnt <= 32'h0;
      end else if (key_wait) begin
        wait_cnt <= wait_cnt + 32'h1;
      end
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn || !clk_en);
  sequence s_take_timing;
    take_timing && clk_en;
  endsequence
  chk_timing_header: assert property ( // [RULE1]
    s_take_timing |=> frm[15:0] == {EV_CONN_TIMING, LEN_CONN_TIMING}
                      && left == 4'h8)
    else $error("timing report header wrong");
  chk_conn_trigger: assert property ( // [RULE2]
    (conn_established || conn_params_updated) |=> timing_pend)
    else $error("connection event not made pending");
  chk_interval_order: assert property ( // [RULE3]
    s_take_timing |=> frm[23:16] == $past(conn[15:8])
                      && frm[31:24] == $past(conn[7:0]))
    else $error("interval not msb first");
  chk_latency_cap: assert property ( // [RULE4]
    s_take_timing |=> {frm[47:40], frm[39:32]} <= LATENCY_MAX
                      && frm[39:32] == $past(lat_capped[7:0]))
    else $error("latency order or cap wrong");
  chk_timeout_field: assert property ( // [RULE5]
    s_take_timing |=> frm[63:48] == $past(link_timeout))
    else $error("timeout field wrong");
  chk_show_digits: assert property ( // [RULE7]
    take_show |=> frm[15:0] == {EV_KEY_SHOW, LEN_KEY_SHOW}
                  && frm[23:16] >= ASCII_ZERO && frm[23:16] <= ASCII_NINE
                  && frm[63:56] >= ASCII_ZERO && frm[63:56] <= ASCII_NINE)
    else $error("passkey digits not ascii");
  chk_show_gate: assert property ( // [RULE8]
    $rose(show_pend) |-> $past(pair_ok))
    else $error("show request without configuration");
  chk_entry_gate: assert property ( // [RULE10]
    $rose(entry_pend) |-> $past(pair_ok))
    else $error("entry request without configuration");
  chk_entry_frame: assert property ( // [RULE9]
    take_entry |=> frm[23:0] == {KEY_KIND_PASSKEY, EV_KEY_ENTRY,
                                 LEN_KEY_ENTRY} && left == 4'h3)
    else $error("entry request frame wrong");
  chk_key_expiry: assert property ( // [RULE12]
    key_expire |=> bond_fail && link_terminate && !key_wait
                   ##1 !bond_fail)
    else $error("deadline expiry not signalled once");
  chk_credit_frame: assert property ( // [RULE13]
    take_credit |=> frm[23:0] == {$past(credit), EV_CREDIT, LEN_CREDIT})
    else $error("credit frame wrong");
  chk_credit_restart: assert property ( // [RULE14]
    take_credit && !data_cmd_freed |=> credit == 8'h00)
    else $error("credits not restarted");
  chk_stall_hold: assert property ( // [RULE15]
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte))
    else $error("byte lost under stall");
endmodule

`default_nettype wire

// ### testbench/hepb_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module hepb_ctrl_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // event stream in
  input wire hepb_pkg::hepb_byte_s tx_byte,
  input wire logic tx_valid,
  output logic tx_ready,
  // behaviour control
  input wire logic stall,
  input wire logic supply_en,
  output logic passkey_supply_command
);
  import hepb_pkg::*;
  logic [7:0] pkt [8];
  logic [7:0] acc [8];
  int wp, pn, npkt, credits;
  int tick;
  // slow mode takes a byte every other cycle only
  assign tx_ready = ~stall | tick[0];
  always_ff @(posedge clk_sys) begin
    tick <= resetn ? tick + 1 : 0;
    passkey_supply_command <= 1'b0;
    if (!resetn) begin
      wp <= 0;
      npkt <= 0;
      credits <= 0;
    end else if (tx_valid && tx_ready) begin
      acc[wp[2:0]] <= tx_byte.data;
      wp <= tx_byte.last ? 0 : wp + 1;
      if (tx_byte.last) begin
        pkt <= acc;
        pkt[wp[2:0]] <= tx_byte.data;
        pn <= wp + 1;
        npkt <= npkt + 1;
        if (acc[1] == EV_CREDIT) credits <= credits + tx_byte.data;
        if (acc[1] == EV_KEY_ENTRY && supply_en)
          passkey_supply_command <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ### testbench/host_event_packet_builder_tb.sv
`timescale 1ns/1ps
`default_nettype none
module host_event_packet_builder_tb;
  import hepb_pkg::*;
  typedef struct {
    logic [31:0] conn;
    int ev;
    int n;
    logic [7:0] b [8];
  } hepb_row_s;
  logic clk_sys = 0;
  logic resetn = 0;
  logic psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, bond_fail, link_terminate, tx_valid, tx_ready;
  logic supply, er;
  logic [4:0] ev = 5'h0;
  logic stall = 0, supply_en = 1, clk_en = 1;
  hepb_byte_s tx_byte;
  hepb_row_s rows [4];
  int err_total = 0, n_compared = 0, nfail = 0, i, j, k, n0;
  always #10 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (bond_fail === 1'b1) nfail <= nfail + 1;
  hepb_builder #(.KEY_WAIT_CYCLES(32'd100)) i_dut (
    .clk_sys(clk_sys), .resetn(resetn), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .conn_established(ev[0]),
    .conn_params_updated(ev[1]), .pair_show_req(ev[2]),
    .pair_entry_req(ev[3]), .passkey_supply_command(supply),
    .data_cmd_freed(ev[4]), .bond_fail(bond_fail),
    .link_terminate(link_terminate), .tx_byte(tx_byte),
    .tx_valid(tx_valid), .tx_ready(tx_ready));
  hepb_ctrl_model i_ctrl (
    .clk_sys(clk_sys), .resetn(resetn), .tx_byte(tx_byte),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .stall(stall),
    .supply_en(supply_en), .passkey_supply_command(supply));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task summarize;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // apb master, waits for pready under a bound
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge clk_sys);
      t++;
    end while (pready !== 1'b1 && t < 50);
    chk(pready, 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task pulse(input int e);
    @(posedge clk_sys);
    ev <= 5'(1 << e);
    @(posedge clk_sys);
    ev <= 5'h0;
  endtask
  task wait_pkt;
    for (k = 0; k < 300 && i_ctrl.npkt == n0; k++) @(posedge clk_sys);
    chk(i_ctrl.npkt, n0 + 1);
  endtask
  initial begin
    rows[0] = '{32'h0123_0c80, 0, 8, '{8'h07, 8'h89, 8'h0c, 8'h80,
                8'h23, 8'h01, 8'h58, 8'h02}};
    rows[1] = '{32'h0500_0006, 1, 8, '{8'h07, 8'h89, 8'h00, 8'h06,
                8'he8, 8'h03, 8'h58, 8'h02}};
    rows[2] = '{32'h0, 2, 8, '{8'h07, 8'h8e, 8'h30, 8'h30, 8'h30,
                8'h31, 8'h32, 8'h33}};
    rows[3] = '{32'h0, 3, 3, '{8'h02, 8'h8f, 8'h01, 8'h0, 8'h0, 8'h0,
                8'h0, 8'h0}};
    repeat (8) @(posedge clk_sys);
    resetn <= 1'b1;
    for (i = 0; i < 5; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0);
      chk(rd, 32'h0);
    end
    apb(1'b0, 8'h14, 32'h0);
    chk(er, 1'b1);
    chk(rd, 32'h0);
    $display("test reset and map done");
    apb(1'b1, OFS_TIMEOUT, 32'h0258);
    apb(1'b1, OFS_PASSKEY, 32'h00_0123);
    apb(1'b0, OFS_PASSKEY, 32'h0);
    chk(rd, 32'h0000_0123);
    apb(1'b1, OFS_CTRL, 32'h3);
    n0 = i_ctrl.npkt;
    pulse(2);
    pulse(3);
    repeat (60) @(posedge clk_sys);
    chk(i_ctrl.npkt, n0);
    $display("test gating done");
    apb(1'b1, OFS_CTRL, 32'h7);
    for (i = 0; i < 4; i++) begin
      stall <= i[0];
      apb(1'b1, OFS_CONN, rows[i].conn);
      n0 = i_ctrl.npkt;
      pulse(rows[i].ev);
      wait_pkt();
      @(posedge clk_sys);
      chk(i_ctrl.pn, rows[i].n);
      for (j = 0; j < 2; j++)
        chk(i_ctrl.pkt[j], rows[i].b[j]);
      for (j = 2; j < rows[i].n; j++)
        chk(i_ctrl.pkt[j], rows[i].b[j]);
      $display("test row %0d done", i);
    end
    stall <= 1'b1;
    @(posedge clk_sys);
    ev <= 5'h10;
    repeat (3) @(posedge clk_sys);
    ev <= 5'h0;
    repeat (100) @(posedge clk_sys);
    chk(i_ctrl.credits, 3);
    chk(i_ctrl.pkt[1], EV_CREDIT);
    $display("test credits done");
    stall <= 1'b0;
    supply_en <= 1'b0;
    n0 = i_ctrl.npkt;
    pulse(3);
    wait_pkt();
    for (k = 0; k < 300 && bond_fail !== 1'b1; k++) @(posedge clk_sys);
    chk(k >= 90 && k <= 100, 1'b1);
    chk(link_terminate, 1'b1);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd[STAT_BOND_FAIL], 1'b1);
    supply_en <= 1'b1;
    n0 = i_ctrl.npkt;
    pulse(3);
    wait_pkt();
    repeat (200) @(posedge clk_sys);
    chk(nfail, 1);
    $display("test deadline done");
    // write one clears the sticky failure flag
    apb(1'b1, OFS_STATUS, 32'h0000_0004);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd[STAT_BOND_FAIL], 1'b0);
    // frozen by clk_en: a connect pulse is never seen
    clk_en <= 1'b0;
    n0 = i_ctrl.npkt;
    pulse(0);
    repeat (20) @(posedge clk_sys);
    chk(i_ctrl.npkt, n0);
    clk_en <= 1'b1;
    // mid-run reset wipes the registers
    @(posedge clk_sys);
    resetn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    apb(1'b0, OFS_CTRL, 32'h0);
    chk(rd, 32'h0);
    $display("test freeze and reset done");
    summarize();
  end
  initial begin
    #400_000;
    err_total++;
    summarize();
  end
endmodule
`default_nettype wire
